// ===== verilog/tcr_pkg.sv
/*
  Package for the cell-delineation status, section-reset and transmit-control register slice.
  Holds the register indices, field positions, reset values and bus and control structs.
  Assumes a single 40 MHz clock domain and a byte-addressed register port (byte address = 4*index).
*/
// Contract
// - selector low four bits name the link whose state is read back
// - selector bit 4 is read-only and flips on every write access
// - state readback refreshed from the selected link when selector write completes
// - readback bits 1:0 show 00 hunt, 01 presync, 10 sync, 11 unused
// - sync status bit per link, live, high only while that link is synchronised
// - one write setting reset bits 7,6,5 together resets all logic
// - writing 1 to reset bit 7 resets the receive section
// - writing 1 to reset bit 6 resets the transmit section
// - writing 1 to reset bit 5 resets the statistics counters
// - eight transmit registers, upper byte link N+8, lower byte link N
// - bits 15 and 7 choose user-only or total transmit cell counting
// - bits 13 and 5 set drop the coset from generated header check
// - bits 12 and 4 enable transmit cell scrambling
// - unused upper bits of selector, readback and reset registers read zero
// - presync moves to sync after programmable run of good headers, default six
// - sync falls to hunt after programmable run of bad headers, default seven
package tcr_pkg;

  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 16;
  localparam int          NUM_LINKS      = 16;
  localparam int          NUM_TX_REGS    = 8;

  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_DLN_PARAM  = 14'h00C9;
  localparam logic [13:0] IDX_LINK_SEL   = 14'h00DC;
  localparam logic [13:0] IDX_STATE_RB   = 14'h00E4;
  localparam logic [13:0] IDX_SYNC_STAT  = 14'h00E6;
  localparam logic [13:0] IDX_RESET_CTL  = 14'h0299;
  localparam logic [13:0] IDX_TX_BASE    = 14'h0318;
  localparam logic [13:0] IDX_IRQ_STAT   = 14'h03F0;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h03F1;

  // field positions
  localparam int          SEL_TOGGLE_BIT = 4;
  localparam int          RST_RX_BIT     = 7;
  localparam int          RST_TX_BIT     = 6;
  localparam int          RST_CNT_BIT    = 5;
  localparam int          TX_USER_BIT    = 7;
  localparam int          TX_NOCOSET_BIT = 5;
  localparam int          TX_SCRAM_BIT   = 4;
  localparam int          TX_HI_OFS      = 8;

  // writable masks and reset values
  localparam logic [15:0] RESET_KEEP_MSK = 16'h011F;
  localparam logic [15:0] TX_CTL_RESET   = 16'h0808;
  localparam logic [3:0]  DELTA_DEFAULT  = 4'h6;
  localparam logic [3:0]  LOSS_CELL_DFLT = 4'h7;
  localparam logic [7:0]  DLN_PARAM_RST  = {DELTA_DEFAULT, LOSS_CELL_DFLT};

  // readback encodings of delineation state
  localparam logic [1:0]  RB_HUNT        = 2'h0;
  localparam logic [1:0]  RB_PRESYNC     = 2'h1;
  localparam logic [1:0]  RB_SYNC        = 2'h2;

  typedef enum logic [1:0] {
    DLN_HUNT    = 2'b00,
    DLN_PRESYNC = 2'b01,
    DLN_SYNC    = 2'b11
  } tcr_dln_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tcr_bus_req_s;

  typedef struct packed {
    logic user_only;
    logic no_coset;
    logic scramble;
  } tcr_tx_ctl_s;

endpackage : tcr_pkg

// ===== verilog/tcr_regs.sv
/*
  Register slice: link selector, delineation readback, live sync vector, section resets,
  per-link transmit controls, one delineation machine per receive link and a level interrupt.
  Assumes cell_strobe and hec_good come from logic on ref_clk; bus master never waits.
*/
// Local design decision: strobed register access.
module tcr_regs #(
  parameter int LINKS = tcr_pkg::NUM_LINKS
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire tcr_pkg::tcr_bus_req_s     bus_req,
  output logic [tcr_pkg::DATA_W-1:0]     bus_rdata,
  input  wire logic [LINKS-1:0]          cell_strobe,
  input  wire logic [LINKS-1:0]          hec_good,
  output logic [LINKS-1:0]               link_in_sync,
  output tcr_pkg::tcr_tx_ctl_s [LINKS-1:0] tx_ctl,
  output logic                           rx_reset_pulse,
  output logic                           tx_reset_pulse,
  output logic                           cnt_reset_pulse,
  output logic                           global_reset_pulse,
  output logic                           irq
);

  // refuse a link count the register layout cannot serve
  if (LINKS != tcr_pkg::NUM_LINKS) begin : g_bad_links
    $error("tcr_regs: LINKS must equal the sixteen-link register layout");
  end

  logic [13:0]               idx;
  logic                      aligned;
  logic                      wr_sel;
  logic                      wr_rst;
  logic                      wr_par;
  logic                      wr_msk;
  logic                      rd_stat;
  logic [15:0]               sel_r;
  logic [15:0]               rb_r;
  logic [15:0]               rst_keep_r;
  logic [7:0]                par_r;
  logic [15:0]               tx_r [tcr_pkg::NUM_TX_REGS];
  logic [15:0]               stat_r;
  logic [15:0]               mask_r;
  logic [15:0]               stat_nxt;
  logic [15:0]               rdata_nxt;
  logic                      glob_r;
  logic [LINKS-1:0]          lost_sync;
  tcr_pkg::tcr_dln_e         cell_delineation_fsm_r [LINKS];

  // map machine state to readback code
  function automatic logic [1:0] rb_code(input tcr_pkg::tcr_dln_e s);
    unique case (s)
      tcr_pkg::DLN_HUNT:    rb_code = tcr_pkg::RB_HUNT;
      tcr_pkg::DLN_PRESYNC: rb_code = tcr_pkg::RB_PRESYNC;
      tcr_pkg::DLN_SYNC:    rb_code = tcr_pkg::RB_SYNC;
      default:             rb_code = tcr_pkg::RB_HUNT;
    endcase
  endfunction : rb_code

  // transmit register slot hit by an index
  function automatic logic is_tx(input logic [13:0] i);
    is_tx = (i >= tcr_pkg::IDX_TX_BASE) &&
            (i <  tcr_pkg::IDX_TX_BASE + 14'(tcr_pkg::NUM_TX_REGS));
  endfunction : is_tx

  // address decode
  assign idx      = bus_req.addr[15:2];
  assign aligned  = (bus_req.addr[1:0] == 2'h0);
  assign wr_sel   = bus_req.wr && aligned && (idx == tcr_pkg::IDX_LINK_SEL);
  assign wr_rst   = bus_req.wr && aligned && (idx == tcr_pkg::IDX_RESET_CTL);
  assign wr_par   = bus_req.wr && aligned && (idx == tcr_pkg::IDX_DLN_PARAM);
  assign wr_msk   = bus_req.wr && aligned && (idx == tcr_pkg::IDX_IRQ_MASK);
  assign rd_stat  = bus_req.rd && aligned && (idx == tcr_pkg::IDX_IRQ_STAT);

  // link selector and access toggle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= 16'h0000;
    end else if (glob_r) begin
      sel_r <= 16'h0000;
    end else begin
      if (wr_sel) begin
        sel_r[3:0] <= bus_req.wdata[3:0];
      end
      if (bus_req.wr) begin
        sel_r[tcr_pkg::SEL_TOGGLE_BIT] <= ~sel_r[tcr_pkg::SEL_TOGGLE_BIT];
      end
    end
  end

  // state readback captured as the selector write completes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rb_r <= 16'h0000;
    end else if (glob_r) begin
      rb_r <= 16'h0000;
    end else if (wr_sel) begin
      rb_r <= {14'h0000, rb_code(cell_delineation_fsm_r[bus_req.wdata[3:0]])};
    end
  end

  // delineation thresholds
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_r <= tcr_pkg::DLN_PARAM_RST;
    end else if (glob_r) begin
      par_r <= tcr_pkg::DLN_PARAM_RST;
    end else if (wr_par) begin
      par_r <= bus_req.wdata[7:0];
    end
  end

  // reset control, request bits self-clear after one pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_keep_r         <= 16'h0000;
      rx_reset_pulse     <= 1'b0;
      tx_reset_pulse     <= 1'b0;
      cnt_reset_pulse    <= 1'b0;
      global_reset_pulse <= 1'b0;
      glob_r             <= 1'b0;
    end else begin
      rx_reset_pulse     <= 1'b0;
      tx_reset_pulse     <= 1'b0;
      cnt_reset_pulse    <= 1'b0;
      global_reset_pulse <= 1'b0;
      glob_r             <= 1'b0;
      if (glob_r) begin
        rst_keep_r <= 16'h0000;
      end else if (wr_rst) begin
        rst_keep_r <= bus_req.wdata & tcr_pkg::RESET_KEEP_MSK;
        rx_reset_pulse  <= bus_req.wdata[tcr_pkg::RST_RX_BIT];
        tx_reset_pulse  <= bus_req.wdata[tcr_pkg::RST_TX_BIT];
        cnt_reset_pulse <= bus_req.wdata[tcr_pkg::RST_CNT_BIT];
        if (&bus_req.wdata[7:5]) begin
          global_reset_pulse <= 1'b1;
          glob_r             <= 1'b1;
        end
      end
    end
  end

  // transmit control registers, one per link pair
  genvar g;
  generate
    for (g = 0; g < tcr_pkg::NUM_TX_REGS; g++) begin : g_tx
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          tx_r[g] <= tcr_pkg::TX_CTL_RESET;
        end else if (glob_r || tx_reset_pulse) begin
          tx_r[g] <= tcr_pkg::TX_CTL_RESET;
        end else if (bus_req.wr && aligned && (idx == tcr_pkg::IDX_TX_BASE + 14'(g))) begin
          tx_r[g] <= bus_req.wdata;
        end
      end
      // lower byte link N, upper byte link N+8
      assign tx_ctl[g].user_only   = tx_r[g][tcr_pkg::TX_USER_BIT];
      assign tx_ctl[g+8].user_only = tx_r[g][tcr_pkg::TX_USER_BIT + tcr_pkg::TX_HI_OFS];
      assign tx_ctl[g].no_coset    = tx_r[g][tcr_pkg::TX_NOCOSET_BIT];
      assign tx_ctl[g+8].no_coset  = tx_r[g][tcr_pkg::TX_NOCOSET_BIT + tcr_pkg::TX_HI_OFS];
      assign tx_ctl[g].scramble    = tx_r[g][tcr_pkg::TX_SCRAM_BIT];
      assign tx_ctl[g+8].scramble  = tx_r[g][tcr_pkg::TX_SCRAM_BIT + tcr_pkg::TX_HI_OFS];
    end
  endgenerate

  // one delineation machine per receive link
  generate
    for (g = 0; g < LINKS; g++) begin : g_cd
      logic [3:0] run_r;
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          cell_delineation_fsm_r[g] <= tcr_pkg::DLN_HUNT;
          run_r                     <= 4'h0;
        end else if (glob_r || rx_reset_pulse) begin
          cell_delineation_fsm_r[g] <= tcr_pkg::DLN_HUNT;
          run_r                     <= 4'h0;
        end else if (cell_strobe[g]) begin
          unique case (cell_delineation_fsm_r[g])
            tcr_pkg::DLN_HUNT: begin
              run_r <= 4'h0;
              if (hec_good[g]) begin
                cell_delineation_fsm_r[g] <= tcr_pkg::DLN_PRESYNC;
              end
            end
            tcr_pkg::DLN_PRESYNC: begin
              if (!hec_good[g]) begin
                cell_delineation_fsm_r[g] <= tcr_pkg::DLN_HUNT;
                run_r                     <= 4'h0;
              end else if (5'(run_r) + 5'h01 >= {1'b0, par_r[7:4]}) begin
                cell_delineation_fsm_r[g] <= tcr_pkg::DLN_SYNC;
                run_r                     <= 4'h0;
              end else begin
                run_r <= run_r + 4'h1;
              end
            end
            tcr_pkg::DLN_SYNC: begin
              if (hec_good[g]) begin
                run_r <= 4'h0;
              end else if (5'(run_r) + 5'h01 >= {1'b0, par_r[3:0]}) begin
                cell_delineation_fsm_r[g] <= tcr_pkg::DLN_HUNT;
                run_r                     <= 4'h0;
              end else begin
                run_r <= run_r + 4'h1;
              end
            end
            default: begin
              cell_delineation_fsm_r[g] <= tcr_pkg::DLN_HUNT;
              run_r                     <= 4'h0;
            end
          endcase
        end
      end
      assign link_in_sync[g] = (cell_delineation_fsm_r[g] == tcr_pkg::DLN_SYNC);
      assign lost_sync[g]    = (cell_delineation_fsm_r[g] == tcr_pkg::DLN_SYNC) &&
                               cell_strobe[g] && !hec_good[g] && !glob_r && !rx_reset_pulse &&
                               (5'(run_r) + 5'h01 >= {1'b0, par_r[3:0]});
    end
  endgenerate

  // sticky loss-of-sync events, set wins over read clear
  always_comb begin
    stat_nxt = rd_stat ? 16'h0000 : stat_r;
    stat_nxt = stat_nxt | lost_sync;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= 16'h0000;
      mask_r <= 16'h0000;
    end else if (glob_r) begin
      stat_r <= 16'h0000;
      mask_r <= 16'h0000;
    end else begin
      stat_r <= stat_nxt;
      if (wr_msk) begin
        mask_r <= bus_req.wdata;
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // read mux, unmapped reads zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (aligned) begin
      if (idx == tcr_pkg::IDX_LINK_SEL) begin
        rdata_nxt = {11'h000, sel_r[4:0]};
      end else if (idx == tcr_pkg::IDX_STATE_RB) begin
        rdata_nxt = {14'h0000, rb_r[1:0]};
      end else if (idx == tcr_pkg::IDX_SYNC_STAT) begin
        rdata_nxt = link_in_sync;
      end else if (idx == tcr_pkg::IDX_RESET_CTL) begin
        rdata_nxt = {7'h00, rst_keep_r[8:0]};
      end else if (idx == tcr_pkg::IDX_DLN_PARAM) begin
        rdata_nxt = {8'h00, par_r};
      end else if (is_tx(idx)) begin
        rdata_nxt = tx_r[3'(idx - tcr_pkg::IDX_TX_BASE)];
      end else if (idx == tcr_pkg::IDX_IRQ_STAT) begin
        rdata_nxt = stat_r;
      end else if (idx == tcr_pkg::IDX_IRQ_MASK) begin
        rdata_nxt = mask_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // checks
  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_toggle;
    @(posedge ref_clk) disable iff (!rst_b)
      bus_req.wr && !glob_r |=> sel_r[4] != $past(sel_r[4]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not flip");

  property p_sel;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_sel && !glob_r |=> sel_r[3:0] == $past(bus_req.wdata[3:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("selector not stored");

  property p_rb_code;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_sel && !glob_r && cell_delineation_fsm_r[bus_req.wdata[3:0]] == tcr_pkg::DLN_SYNC
      |=> rb_r[1:0] == tcr_pkg::RB_SYNC;
  endproperty
  a_rb_code: assert property (p_rb_code) else $error("readback code wrong");

  property p_rx_rst;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_rst && !glob_r && bus_req.wdata[tcr_pkg::RST_RX_BIT] ##1 !wr_rst
      |-> s_one_pulse(rx_reset_pulse);
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receive reset pulse wrong");

  property p_glob;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_rst && !glob_r && (&bus_req.wdata[7:5])
      |=> global_reset_pulse ##1 (sel_r[3:0] == 4'h0 && !link_in_sync[0]);
  endproperty
  a_glob: assert property (p_glob) else $error("global reset not applied");

  property p_tx_hi;
    @(posedge ref_clk) disable iff (!rst_b)
      bus_req.wr && aligned && idx == tcr_pkg::IDX_TX_BASE && !glob_r && !tx_reset_pulse
      |=> tx_ctl[8].user_only == $past(bus_req.wdata[15]) &&
          tx_ctl[0].scramble == $past(bus_req.wdata[4]);
  endproperty
  a_tx_hi: assert property (p_tx_hi) else $error("transmit control not split");

  property p_presync_bad;
    @(posedge ref_clk) disable iff (!rst_b)
      cell_delineation_fsm_r[0] == tcr_pkg::DLN_PRESYNC && cell_strobe[0] && !hec_good[0]
      |=> cell_delineation_fsm_r[0] == tcr_pkg::DLN_HUNT;
  endproperty
  a_presync_bad: assert property (p_presync_bad) else $error("presync kept bad cell");

  property p_sync_rise;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(link_in_sync[0]) |-> $past(cell_delineation_fsm_r[0]) == tcr_pkg::DLN_PRESYNC;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync without presync");

  property p_rst_rd;
    @(posedge ref_clk) disable iff (!rst_b)
      bus_req.rd && aligned && idx == tcr_pkg::IDX_RESET_CTL |=> bus_rdata[15:5] == 11'h000 ||
      bus_rdata[15:9] == 7'h00 && bus_rdata[7:5] == 3'h0;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("reset register reads set bits");

endmodule : tcr_regs

// ===== sim/atm_tc_cd_status_reset_txctl_tb_top.sv
/*
  Self-checking bench for the delineation status, section reset and transmit control slice.
  Assumes one 40 MHz clock, byte address = 4 * index, read data in the cycle after the strobe.
*/
module atm_tc_cd_status_reset_txctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                        ref_clk;
  logic                        rst_b;
  tcr_pkg::tcr_bus_req_s       bus_req;
  logic [15:0]                 bus_rdata;
  logic [15:0]                 cell_strobe;
  logic [15:0]                 hec_good;
  logic [15:0]                 link_in_sync;
  tcr_pkg::tcr_tx_ctl_s [15:0] tx_ctl;
  logic                        rx_p, tx_p, cnt_p, glob_p, irq;
  int                          num_errors, n_tests, seed, cyc;
  int                          st[16], cnt[16];
  logic [15:0]                 txm[8];
  logic [15:0]                 sts, msk, rstm, lm;
  logic [3:0]                  sel, lk;
  logic                        tog;
  logic [1:0]                  rb;
  logic [7:0]                  par;

  tcr_regs #(.LINKS(16)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cell_strobe(cell_strobe), .hec_good(hec_good), .link_in_sync(link_in_sync),
    .tx_ctl(tx_ctl), .rx_reset_pulse(rx_p), .tx_reset_pulse(tx_p),
    .cnt_reset_pulse(cnt_p), .global_reset_pulse(glob_p), .irq(irq));

  // 25 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // model back to power-up values
  task automatic mreset();
    sel = '0;
    tog = 1'b0;
    rb = '0;
    rstm = '0;
    msk = '0;
    sts = '0;
    par = tcr_pkg::DLN_PARAM_RST;
    for (int i = 0; i < 16; i++) begin
      st[i] = 0;
      cnt[i] = 0;
      txm[i % 8] = 16'h0808;
    end
  endtask : mreset

  function automatic logic [15:0] syncv();
    logic [15:0] v;
    for (int l = 0; l < 16; l++) v[l] = (st[l] == 2);
    return v;
  endfunction : syncv

  // expected read value of one register index
  function automatic logic [15:0] mval(input logic [13:0] ix);
    if (ix == tcr_pkg::IDX_LINK_SEL) return {11'h0, tog, sel};
    if (ix == tcr_pkg::IDX_STATE_RB) return {14'h0, rb};
    if (ix == tcr_pkg::IDX_SYNC_STAT) return syncv();
    if (ix == tcr_pkg::IDX_RESET_CTL) return rstm;
    if (ix == tcr_pkg::IDX_DLN_PARAM) return {8'h00, par};
    if (ix >= tcr_pkg::IDX_TX_BASE && ix < tcr_pkg::IDX_TX_BASE + 14'h8) return txm[ix[2:0]];
    if (ix == tcr_pkg::IDX_IRQ_STAT) return sts;
    if (ix == tcr_pkg::IDX_IRQ_MASK) return msk;
    return 16'h0000;
  endfunction : mval

  // delineation machine model: hunt, presync, sync
  task automatic step(input int l, input logic g);
    if (st[l] == 0) begin
      st[l] = g ? 1 : 0;
      cnt[l] = 0;
    end else if (st[l] == 1) begin
      cnt[l] = g ? cnt[l] + 1 : 0;
      st[l] = !g ? 0 : (cnt[l] >= int'(par[7:4])) ? 2 : 1;
      if (st[l] == 2) cnt[l] = 0;
    end else begin
      cnt[l] = g ? 0 : cnt[l] + 1;
      if (cnt[l] >= int'(par[3:0])) begin
        st[l] = 0;
        cnt[l] = 0;
        sts[l] = 1'b1;
      end
    end
  endtask : step

  task automatic cells(input logic [15:0] m, input logic [15:0] gm, input int n);
    repeat (n) begin
      cell_strobe <= m;
      hec_good <= gm;
      @(posedge ref_clk);
      for (int l = 0; l < 16; l++) if (m[l]) step(l, gm[l]);
    end
    cell_strobe <= '0;
    hec_good <= 16'($random(seed));
    @(posedge ref_clk);
  endtask : cells

  // one-cycle write, then pulse check in the two following cycles
  task automatic wr(input logic [13:0] ix, input logic [15:0] d);
    logic [3:0] ep;
    ep = '0;
    tog = ~tog;
    if (ix == tcr_pkg::IDX_LINK_SEL) begin
      sel = d[3:0];
      rb = 2'(st[d[3:0]]);
    end else if (ix == tcr_pkg::IDX_RESET_CTL) begin
      ep = {&d[7:5], d[7:5]};
      rstm = d & 16'h011F;
      for (int i = 0; i < 16; i++) begin
        if (d[7]) st[i] = 0;
        if (d[7]) cnt[i] = 0;
        if (d[6]) txm[i % 8] = 16'h0808;
      end
    end else if (ix >= tcr_pkg::IDX_TX_BASE && ix < tcr_pkg::IDX_TX_BASE + 14'h8) begin
      txm[ix[2:0]] = d;
    end else if (ix == tcr_pkg::IDX_IRQ_MASK) begin
      msk = d;
    end else if (ix == tcr_pkg::IDX_DLN_PARAM) begin
      par = d[7:0];
    end
    bus_req <= '{addr: {ix, 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    cmp("reset pulses", {12'h0, ep}, {12'h0, glob_p, rx_p, tx_p, cnt_p});
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("pulse width", 16'h0000, {12'h0, glob_p, rx_p, tx_p, cnt_p});
    if (&ep) mreset();
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    logic [15:0] e;
    e = (a[1:0] == 2'b00) ? mval(a[15:2]) : 16'h0000;
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    cmp($sformatf("read %h", a), e, bus_rdata);
    if (a == {tcr_pkg::IDX_IRQ_STAT, 2'b00}) sts = '0;
    @(posedge ref_clk);
  endtask : rd

  task automatic chk_out();
    int h;
    logic [15:0] e;
    @(negedge ref_clk);
    cmp("sync lines", syncv(), link_in_sync);
    cmp("irq", {15'h0, |(sts & msk)}, {15'h0, irq});
    for (int l = 0; l < 16; l++) begin
      h = (l / 8) * 8;
      e = {13'h0, txm[l % 8][h + 7], txm[l % 8][h + 5], txm[l % 8][h + 4]};
      cmp("tx ctl", e, {13'h0, tx_ctl[l]});
    end
    @(posedge ref_clk);
  endtask : chk_out

  task automatic check_all();
    rd({tcr_pkg::IDX_LINK_SEL, 2'b00});
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    rd({tcr_pkg::IDX_SYNC_STAT, 2'b00});
    rd({tcr_pkg::IDX_RESET_CTL, 2'b00});
    rd({tcr_pkg::IDX_IRQ_MASK, 2'b00});
    for (int k = 0; k < 8; k++) rd({tcr_pkg::IDX_TX_BASE + 14'(k), 2'b00});
    rd({tcr_pkg::IDX_IRQ_STAT, 2'b00});
    chk_out();
  endtask : check_all

  initial begin
    seed = 37;
    rst_b = 1'b0;
    bus_req = '0;
    cell_strobe = '0;
    hec_good = '0;
    mreset();
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    // power-up values, unmapped and misaligned places
    check_all();
    rd({tcr_pkg::IDX_DLN_PARAM, 2'b00});
    rd(16'h0400);
    rd(16'h0372);
    // random transmit controls with reserved bits at their normal values
    for (int k = 0; k < 8; k++) wr(tcr_pkg::IDX_TX_BASE + 14'(k), (16'($random(seed)) & 16'hB0B0) | 16'h0808);
    wr(14'h0100, 16'($random(seed)));
    check_all();
    // one random link and link 0 through presync into sync, others kept hunting
    lk = 4'($random(seed));
    lm = (16'h0001 << lk) | 16'h0001;
    cells(16'hFFFF, lm, 1);
    wr(tcr_pkg::IDX_LINK_SEL, 16'hFFF0 | {12'h0, lk});
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    cells(lm, lm, 4);
    rd({tcr_pkg::IDX_SYNC_STAT, 2'b00});
    cells(lm, lm, 2);
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    wr(tcr_pkg::IDX_LINK_SEL, {12'h0, lk});
    check_all();
    wr(tcr_pkg::IDX_LINK_SEL, {12'h0, lk ^ 4'h1});
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    // loss of sync raises a masked, sticky event
    wr(tcr_pkg::IDX_IRQ_MASK, lm);
    cells(lm, 16'h0000, 6);
    chk_out();
    cells(lm, 16'h0000, 1);
    chk_out();
    wr(tcr_pkg::IDX_IRQ_MASK, 16'h0000);
    chk_out();
    wr(tcr_pkg::IDX_IRQ_MASK, lm);
    chk_out();
    rd({tcr_pkg::IDX_IRQ_STAT, 2'b00});
    chk_out();
    // presync falls back on a bad header
    cells(lm, lm, 1);
    cells(lm, 16'h0000, 1);
    wr(tcr_pkg::IDX_LINK_SEL, {12'h0, lk});
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    // shorter thresholds: three good cells to sync, two bad to hunt
    wr(tcr_pkg::IDX_DLN_PARAM, 16'h0032);
    cells(lm, lm, 4);
    rd({tcr_pkg::IDX_SYNC_STAT, 2'b00});
    cells(lm, 16'h0000, 2);
    chk_out();
    // section resets one by one
    // reserved bits zero
    cells(lm, lm, 1);
    wr(tcr_pkg::IDX_RESET_CTL, 16'h0080);
    wr(tcr_pkg::IDX_LINK_SEL, {12'h0, lk});
    rd({tcr_pkg::IDX_STATE_RB, 2'b00});
    wr(tcr_pkg::IDX_RESET_CTL, 16'h0040);
    check_all();
    wr(tcr_pkg::IDX_RESET_CTL, 16'h0020);
    // global reset with live state everywhere
    cells(lm, lm, 1);
    wr(tcr_pkg::IDX_LINK_SEL, {12'h0, lk});
    wr(tcr_pkg::IDX_TX_BASE + 14'h3, 16'hB8B8);
    wr(tcr_pkg::IDX_IRQ_MASK, 16'hFFFF);
    wr(tcr_pkg::IDX_RESET_CTL, 16'h00E0);
    check_all();
    rd({tcr_pkg::IDX_DLN_PARAM, 2'b00});
    conclude();
  end
endmodule : atm_tc_cd_status_reset_txctl_tb_top
